/* File: core/dscc_clock_control.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dscc_map.svh"

module dscc_clock_control (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr_en,
	input wire logic sfr_rd_en,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic fast_crystal_in,
	input wire logic fast_rc_in,
	input wire logic slow_crystal_in,
	input wire logic slow_rc_in,
	input wire logic idle_mode,
	input wire logic power_down_mode,
	input wire logic pin_mode_clock_out,
	input wire logic cfg_load,
	input wire logic [7:0] config_word_low,
	output logic sys_clk_tick,
	output logic system_is_fast,
	output logic clock_output,
	output logic clock_output_oe,
	output logic fast_osc_enable,
	output logic slow_osc_enable,
	output logic fast_crystal_select,
	output logic slow_crystal_select,
	output logic peripheral_clock_enable,
	output logic [6:0] fast_rc_trim_value
);

	logic slow_type_reg;
	logic fast_type_reg;
	logic slow_stop_reg;
	logic pgate_reg;
	logic fast_stop_reg;
	logic sel_reg;
	logic [1:0] psc_reg;
	logic [6:0] trim_reg;
	dscc_pkg::dscc_src_t active_src_reg;
	dscc_pkg::dscc_src_t active_src_next;
	logic fast_stop_next;
	logic sel_next;
	logic wr_ctrl;
	logic wr_trim;
	logic [3:0] osc_tick;
	logic fast_tick;
	logic slow_tick;
	logic src_tick;
	logic wrap;
	logic psc_tick;
	logic [7:0] ctrl_value;

	assign wr_ctrl = sfr_wr_en && (sfr_addr == `DSCC_CTRL_ADDR);
	assign wr_trim = sfr_wr_en && (sfr_addr == `DSCC_TRIM_ADDR);

	dscc_osc_sync u_sync (
		.clock(clock),
		.rst_b(rst_b),
		.osc_in({slow_rc_in, slow_crystal_in, fast_rc_in, fast_crystal_in}),
		.osc_tick(osc_tick)
	);

	// source type picks the oscillator for each leg
	assign fast_tick = fast_type_reg ? osc_tick[0] : osc_tick[1];
	assign slow_tick = slow_type_reg ? osc_tick[2] : osc_tick[3];
	assign src_tick = (active_src_reg == dscc_pkg::DSCC_FAST) ? fast_tick : slow_tick;

	dscc_prescaler u_psc (
		.clock(clock),
		.rst_b(rst_b),
		.src_tick(src_tick),
		.ratio(psc_reg),
		.wrap(wrap),
		.sys_tick(psc_tick)
	);

	// stop and select are checked as a pair so neither half sticks
	always_comb begin
		fast_stop_next = fast_stop_reg;
		sel_next = sel_reg;
		if (!sel_reg) begin
			fast_stop_next = sfr_wdata[`DSCC_FAST_STOP_BIT];
		end
		if (!fast_stop_reg) begin
			sel_next = sfr_wdata[`DSCC_SEL_BIT];
		end
		if (fast_stop_next && sel_next) begin
			fast_stop_next = fast_stop_reg;
			sel_next = sel_reg;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			slow_type_reg <= 1'b0;
			fast_type_reg <= 1'b0;
			slow_stop_reg <= 1'b1;
			pgate_reg <= 1'b0;
			fast_stop_reg <= 1'b0;
			sel_reg <= 1'b0;
			psc_reg <= 2'h3;
		end else if (wr_ctrl) begin
			if (sel_reg) begin
				slow_type_reg <= sfr_wdata[`DSCC_SLOW_TYPE_BIT];
			end
			if (!sel_reg) begin
				fast_type_reg <= sfr_wdata[`DSCC_FAST_TYPE_BIT];
			end
			slow_stop_reg <= sfr_wdata[`DSCC_SLOW_STOP_BIT];
			pgate_reg <= sfr_wdata[`DSCC_PGATE_BIT];
			fast_stop_reg <= fast_stop_next;
			sel_reg <= sel_next;
			psc_reg <= sfr_wdata[`DSCC_PSC_HI:`DSCC_PSC_LO];
		end
	end

	// factory trim load wins over a software write in the same cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			trim_reg <= `DSCC_TRIM_RESET;
		end else if (cfg_load) begin
			trim_reg <= config_word_low[`DSCC_TRIM_HI:0];
		end else if (wr_trim) begin
			trim_reg <= sfr_wdata[`DSCC_TRIM_HI:0];
		end
	end

	// source follows select only at a divider wrap
	always_comb begin
		active_src_next = active_src_reg;
		unique case (active_src_reg)
			dscc_pkg::DSCC_SLOW: begin
				if (wrap && sel_reg) begin
					active_src_next = dscc_pkg::DSCC_FAST;
				end
			end
			dscc_pkg::DSCC_FAST: begin
				if (wrap && !sel_reg) begin
					active_src_next = dscc_pkg::DSCC_SLOW;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			active_src_reg <= dscc_pkg::DSCC_SLOW;
		end else begin
			active_src_reg <= active_src_next;
		end
	end

	assign ctrl_value = {slow_type_reg, fast_type_reg, slow_stop_reg, pgate_reg,
		fast_stop_reg, sel_reg, psc_reg};

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd_en) begin
			if (sfr_addr == `DSCC_CTRL_ADDR) begin
				sfr_rdata <= ctrl_value;
			end else if (sfr_addr == `DSCC_TRIM_ADDR) begin
				sfr_rdata <= {1'b0, trim_reg};
			end else begin
				sfr_rdata <= 8'h00;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sys_clk_tick <= 1'b0;
			system_is_fast <= 1'b0;
		end else begin
			sys_clk_tick <= psc_tick;
			system_is_fast <= (active_src_reg == dscc_pkg::DSCC_FAST);
		end
	end

	// system clock halved on the output pin
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			clock_output <= 1'b0;
			clock_output_oe <= 1'b0;
		end else begin
			clock_output_oe <= pin_mode_clock_out;
			if (!pin_mode_clock_out) begin
				clock_output <= 1'b0;
			end else if (psc_tick) begin
				clock_output <= ~clock_output;
			end
		end
	end

	// oscillator, crystal pin and peripheral gating
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fast_osc_enable <= 1'b0;
			slow_osc_enable <= 1'b1;
			fast_crystal_select <= 1'b0;
			slow_crystal_select <= 1'b0;
			peripheral_clock_enable <= 1'b1;
			fast_rc_trim_value <= `DSCC_TRIM_RESET;
		end else begin
			fast_osc_enable <= !power_down_mode && !(fast_stop_reg && !sel_reg);
			slow_osc_enable <= !(power_down_mode && slow_stop_reg);
			fast_crystal_select <= fast_type_reg;
			slow_crystal_select <= slow_type_reg;
			peripheral_clock_enable <= !power_down_mode && !(idle_mode && pgate_reg);
			fast_rc_trim_value <= trim_reg;
		end
	end

	// helper: source ticks since the last divider wrap
	logic [4:0] gap_cnt_reg;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			gap_cnt_reg <= 5'h0;
		end else if (wrap) begin
			gap_cnt_reg <= 5'h0;
		end else if (src_tick) begin
			gap_cnt_reg <= gap_cnt_reg + 5'h1;
		end
	end

	sequence wrap_s;
		wrap;
	endsequence

	sequence switch_s;
		!$stable(active_src_reg);
	endsequence

	slow_type_lock_a: assert property (@(posedge clock) disable iff (!rst_b)
		wr_ctrl && !sel_reg |=> $stable(slow_type_reg))
		else $error("slow type changed outside fast mode");

	fast_type_lock_a: assert property (@(posedge clock) disable iff (!rst_b)
		wr_ctrl && sel_reg |=> $stable(fast_type_reg))
		else $error("fast type changed outside slow mode");

	stop_select_excl_a: assert property (@(posedge clock) disable iff (!rst_b)
		!(fast_stop_reg && sel_reg))
		else $error("fast stop and fast select both set");

	select_lock_a: assert property (@(posedge clock) disable iff (!rst_b)
		wr_ctrl && fast_stop_reg |=> $stable(sel_reg))
		else $error("select changed while fast clock stopped");

	illegal_write_a: assert property (@(posedge clock) disable iff (!rst_b)
		wr_ctrl && !sel_reg && !fast_stop_reg && sfr_wdata[`DSCC_FAST_STOP_BIT]
		&& sfr_wdata[`DSCC_SEL_BIT] |=> !fast_stop_reg && !sel_reg)
		else $error("illegal stop and select write accepted");

	psc_settle_a: assert property (@(posedge clock) disable iff (!rst_b)
		gap_cnt_reg < `DSCC_PSC_MAX_TICKS)
		else $error("prescaler period above 16 source ticks");

	switch_at_wrap_a: assert property (@(posedge clock) disable iff (!rst_b)
		switch_s |-> $past(wrap) ##1 sys_clk_tick)
		else $error("source switched away from a divider wrap");

	tick_after_wrap_a: assert property (@(posedge clock) disable iff (!rst_b)
		wrap_s |=> psc_tick ##1 sys_clk_tick)
		else $error("system tick missing after wrap");

	clock_out_a: assert property (@(posedge clock) disable iff (!rst_b)
		psc_tick && pin_mode_clock_out |=> clock_output != $past(clock_output))
		else $error("clock output did not toggle");

	slow_stop_a: assert property (@(posedge clock) disable iff (!rst_b)
		power_down_mode && slow_stop_reg |=> !slow_osc_enable)
		else $error("slow oscillator running in power-down");

	trim_load_a: assert property (@(posedge clock) disable iff (!rst_b)
		cfg_load |=> ##1 fast_rc_trim_value == $past(config_word_low[6:0], 2))
		else $error("trim not loaded from config word");

	periph_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
		idle_mode && pgate_reg |=> !peripheral_clock_enable)
		else $error("peripherals clocked in gated idle");

endmodule // dscc_clock_control

`default_nettype wire

/* File: core/dscc_map.svh */
`ifndef DSCC_MAP_SVH
`define DSCC_MAP_SVH

// register addresses on the special function register port
`define DSCC_CTRL_ADDR 8'hd8
`define DSCC_TRIM_ADDR 8'hf6

// system_clock_control fields
`define DSCC_CTRL_RESET 8'h23
`define DSCC_SLOW_TYPE_BIT 7
`define DSCC_FAST_TYPE_BIT 6
`define DSCC_SLOW_STOP_BIT 5
`define DSCC_PGATE_BIT 4
`define DSCC_FAST_STOP_BIT 3
`define DSCC_SEL_BIT 2
`define DSCC_PSC_HI 1
`define DSCC_PSC_LO 0

// fast_rc_trim fields
`define DSCC_TRIM_HI 6
`define DSCC_TRIM_RESET 7'h40

// prescaler terminal counts and longest settle, in source ticks
`define DSCC_PSC_DIV16_LAST 4'hf
`define DSCC_PSC_DIV4_LAST 4'h3
`define DSCC_PSC_DIV2_LAST 4'h1
`define DSCC_PSC_DIV1_LAST 4'h0
`define DSCC_PSC_RESET_LAST 4'h0
`define DSCC_PSC_MAX_TICKS 5'h10

`endif

/* File: core/dscc_pkg.sv */
`include "dscc_map.svh"

package dscc_pkg;

	typedef enum logic {DSCC_SLOW, DSCC_FAST} dscc_src_t;

	// prescaler code to last count of the divider
	function automatic logic [3:0] dscc_psc_last(input logic [1:0] code);
		logic [3:0] last;
		last = `DSCC_PSC_DIV1_LAST;
		case (code)
			2'h0: last = `DSCC_PSC_DIV16_LAST;
			2'h1: last = `DSCC_PSC_DIV4_LAST;
			2'h2: last = `DSCC_PSC_DIV2_LAST;
			default: last = `DSCC_PSC_DIV1_LAST;
		endcase
		return last;
	endfunction

endpackage

/* File: core/dscc_osc_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// two-stage sync of the oscillator pins, rising-edge ticks after
module dscc_osc_sync (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [3:0] osc_in,
	output logic [3:0] osc_tick
);

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_sync
			logic meta_reg;
			logic sync_reg;
			logic last_reg;
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
					last_reg <= 1'b0;
				end else begin
					meta_reg <= osc_in[i];
					sync_reg <= meta_reg;
					last_reg <= sync_reg;
				end
			end
			assign osc_tick[i] = sync_reg & ~last_reg;
		end
	endgenerate

endmodule // dscc_osc_sync

`default_nettype wire

/* File: core/dscc_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dscc_map.svh"

// divides source ticks; new ratio is taken only at a wrap
module dscc_prescaler (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic src_tick,
	input wire logic [1:0] ratio,
	output logic wrap,
	output logic sys_tick
);

	logic [3:0] cnt_reg;
	logic [3:0] last_reg;

	assign wrap = src_tick && (cnt_reg == last_reg);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 4'h0;
			last_reg <= `DSCC_PSC_RESET_LAST;
		end else if (wrap) begin
			cnt_reg <= 4'h0;
			last_reg <= dscc_pkg::dscc_psc_last(ratio);
		end else if (src_tick) begin
			cnt_reg <= cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sys_tick <= 1'b0;
		end else begin
			sys_tick <= wrap;
		end
	end

endmodule // dscc_prescaler

`default_nettype wire

/* File: tb/tb_dual_system_clock_control.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_dual_system_clock_control;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr_en = 1'b0;
	logic sfr_rd_en = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic [4:0] cnt = 5'h00;
	logic idle_mode = 1'b0;
	logic power_down_mode = 1'b0;
	logic pin_mode_clock_out = 1'b0;
	logic cfg_load = 1'b0;
	logic [7:0] config_word_low = 8'h00;
	logic sys_clk_tick, system_is_fast, clock_output, clock_output_oe;
	logic fast_osc_enable, slow_osc_enable, fast_crystal_select, slow_crystal_select;
	logic peripheral_clock_enable;
	logic [6:0] fast_rc_trim_value;
	int n_fail = 0;
	int checks_done = 0;
	int gap;
	logic [7:0] rv;
	logic co;

	always #2 clock = ~clock;

	// oscillator pins: periods of 4, 8, 16 and 32 cycles
	always @(posedge clock) cnt <= cnt + 5'h01;

	dscc_clock_control dut (
		.clock(clock),
		.rst_b(rst_b),
		.sfr_addr(sfr_addr),
		.sfr_wr_en(sfr_wr_en),
		.sfr_rd_en(sfr_rd_en),
		.sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata),
		.fast_crystal_in(cnt[2]),
		.fast_rc_in(cnt[1]),
		.slow_crystal_in(cnt[4]),
		.slow_rc_in(cnt[3]),
		.idle_mode(idle_mode),
		.power_down_mode(power_down_mode),
		.pin_mode_clock_out(pin_mode_clock_out),
		.cfg_load(cfg_load),
		.config_word_low(config_word_low),
		.sys_clk_tick(sys_clk_tick),
		.system_is_fast(system_is_fast),
		.clock_output(clock_output),
		.clock_output_oe(clock_output_oe),
		.fast_osc_enable(fast_osc_enable),
		.slow_osc_enable(slow_osc_enable),
		.fast_crystal_select(fast_crystal_select),
		.slow_crystal_select(slow_crystal_select),
		.peripheral_clock_enable(peripheral_clock_enable),
		.fast_rc_trim_value(fast_rc_trim_value)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		if (n_fail == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr_en <= 1'b1;
		@(posedge clock);
		sfr_wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		sfr_addr <= a;
		sfr_rd_en <= 1'b1;
		@(posedge clock);
		sfr_rd_en <= 1'b0;
		#1 d = sfr_rdata;
	endtask

	// control write, then read back
	task automatic wcheck(input logic [7:0] d, input logic [7:0] e);
		wr(8'hd8, d);
		rd(8'hd8, rv);
		check(16'(rv), 16'(e));
	endtask

	task automatic next_tick(output int n);
		n = 0;
		do begin
			@(posedge clock);
			#1 n++;
		end while (sys_clk_tick !== 1'b1 && n < 600);
	endtask

	// third gap is past any pending ratio or source change
	task automatic measure(input int exp);
		next_tick(gap);
		next_tick(gap);
		next_tick(gap);
		check(16'(gap), 16'(exp));
	endtask

	task automatic wait_fast(input logic e);
		int i;
		i = 0;
		while (system_is_fast !== e && i < 100) begin
			@(posedge clock);
			#1 i++;
		end
		check(16'(system_is_fast), 16'(e));
	endtask

	task automatic t_reset();
		rd(8'hd8, rv);
		check(16'(rv), 16'h0023);
		check(16'(system_is_fast), 16'h0000);
		check(16'(slow_crystal_select), 16'h0000);
		check(16'(clock_output), 16'h0000);
		rd(8'hf6, rv);
		check(16'(rv), 16'h0040);
	endtask

	task automatic t_prescale();
		int div [4] = '{16, 4, 2, 1};
		for (int c = 0; c < 4; c++) begin
			wr(8'hd8, 8'h20 | 8'(c));
			measure(16 * div[c]);
		end
	endtask

	task automatic t_control();
		wcheck(8'ha3, 8'h23);
		wcheck(8'h63, 8'h63);
		check(16'(fast_crystal_select), 16'h0001);
		wcheck(8'h6f, 8'h63);
		// crystal model is stable at once; type is set before select
		wcheck(8'h67, 8'h67);
		wait_fast(1'b1);
		measure(8);
		wcheck(8'he7, 8'he7);
		check(16'(slow_crystal_select), 16'h0001);
		wcheck(8'ha7, 8'he7);
		wcheck(8'hef, 8'he7);
		wcheck(8'he3, 8'he3);
		wait_fast(1'b0);
		measure(32);
		wcheck(8'heb, 8'heb);
		repeat (2) @(posedge clock);
		#1 check(16'(fast_osc_enable), 16'h0000);
		wcheck(8'hef, 8'heb);
		wcheck(8'he3, 8'he3);
		repeat (2) @(posedge clock);
		#1 check(16'(fast_osc_enable), 16'h0001);
		// fast internal rc leg, one bit changed per write
		wcheck(8'ha3, 8'ha3);
		check(16'(fast_crystal_select), 16'h0000);
		wcheck(8'ha7, 8'ha7);
		wait_fast(1'b1);
		measure(4);
		wcheck(8'ha3, 8'ha3);
		wait_fast(1'b0);
	endtask

	task automatic t_clock_out();
		@(posedge clock);
		pin_mode_clock_out <= 1'b1;
		next_tick(gap);
		@(posedge clock);
		#1 co = clock_output;
		next_tick(gap);
		@(posedge clock);
		#1 check(16'(co ^ clock_output), 16'h0001);
		check(16'(clock_output_oe), 16'h0001);
	endtask

	task automatic t_low_power();
		wcheck(8'hf3, 8'hf3);
		@(posedge clock);
		idle_mode <= 1'b1;
		repeat (3) @(posedge clock);
		#1 check(16'(peripheral_clock_enable), 16'h0000);
		@(posedge clock);
		idle_mode <= 1'b0;
		power_down_mode <= 1'b1;
		repeat (3) @(posedge clock);
		#1 check(16'(slow_osc_enable), 16'h0000);
		wcheck(8'hd3, 8'hd3);
		repeat (2) @(posedge clock);
		#1 check(16'(slow_osc_enable), 16'h0001);
		@(posedge clock);
		power_down_mode <= 1'b0;
	endtask

	task automatic t_trim();
		wr(8'hf6, 8'h95);
		rd(8'hf6, rv);
		check(16'(rv), 16'h0015);
		check(16'(fast_rc_trim_value), 16'h0015);
		@(posedge clock);
		config_word_low <= 8'hea;
		cfg_load <= 1'b1;
		@(posedge clock);
		cfg_load <= 1'b0;
		rd(8'hf6, rv);
		check(16'(rv), 16'h006a);
		rd(8'h10, rv);
		check(16'(rv), 16'h0000);
	endtask

	initial begin
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		t_reset();
		t_prescale();
		t_control();
		t_clock_out();
		t_low_power();
		t_trim();
		conclude();
	end

	initial begin
		repeat (40000) @(posedge clock);
		n_fail++;
		conclude();
	end
endmodule // tb_dual_system_clock_control

`default_nettype wire
